// >>> hdl/cmb_store.sv
// CAN message buffer store: three transmit buffers and a receive FIFO.
//
// Contract
// - Exactly three independent transmit buffers allow back-to-back frames.
// - Each transmit buffer holds 13 frame bytes, priority and 2 stamp bytes.
// - Software selects an empty buffer; it is mapped into one window.
// - Non-empty buffers are scheduled; empty flag sets after success.
// - Transmit interrupt while any unmasked empty flag is set.
// - Among pending buffers the smallest priority value is sent first.
// - Priority selection reruns at every arbitration, also after errors.
// - Software requests abort; a frame in transmission is never aborted.
// - Abort grant sets ack, empty flag and transmit interrupt in the same cycle.
// - Abort ack reads 1 for an aborted frame, 0 for a sent one.
// - Five-stage receive FIFO; only the foreground buffer is visible.
// - Each receive buffer is 15 bytes including the time stamp.
// - Incoming bytes go to the background buffer while filtering runs.
// - Valid accepted frame is pushed, full flag and interrupt raised.
// - Invalid or rejected frames are not pushed and get overwritten.
// - Own frames are captured but not pushed, interrupted or acknowledged.
// - In loopback own frames are handled like any incoming frame.
// - After lost arbitration the winning frame is received normally.
// - Accepted frame into a full FIFO is dropped with overrun interrupt.
// - Transmission continues while full; reception resumes once freed.
// - Equal lowest priority goes to the lower buffer index.
// - With stamping on, the timer is stored after a valid end of frame.
`timescale 1ns/1ps
`default_nettype none
module cmb_store
  import cmb_pkg::*;
#(
  parameter int DEPTH = RX_DEPTH
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_i,
  input  wire logic                   loopback_i,
  input  wire logic                   timestamp_enable_i,
  input  wire logic [STAMP_W-1:0]     timer_i,
  input  wire logic                   tx_sel_wr_i,
  input  wire logic [2:0]             tx_sel_wdata_i,
  input  wire cmb_byte_wr_t           tx_win_wr_i,
  input  wire logic [3:0]             tx_win_raddr_i,
  input  wire logic [2:0]             tx_empty_clr_i,
  input  wire logic [2:0]             abort_req_set_i,
  input  wire logic [2:0]             tx_irq_mask_i,
  input  wire cmb_tx_evt_t            tx_evt_i,
  input  wire cmb_byte_wr_t           rx_byte_i,
  input  wire cmb_rx_end_t            rx_end_i,
  input  wire logic [3:0]             rx_fg_raddr_i,
  input  wire logic                   rx_full_clr_i,
  input  wire logic                   rx_irq_en_i,
  input  wire logic                   overrun_clr_i,
  input  wire logic                   overrun_irq_en_i,
  output logic [2:0]                  tx_buffer_select_reg_o,
  output logic [2:0]                  tx_buffer_empty_flag_o,
  output logic [2:0]                  abort_request_bit_o,
  output logic [2:0]                  abort_ack_flag_o,
  output logic [7:0]                  tx_win_rdata_o,
  output logic                        tx_irq_o,
  output logic                        tx_req_o,
  output logic [TXB_BYTES-1:0][7:0]   tx_frame_o,
  output logic                        tx_busy_o,
  output logic                        rx_ack_allow_o,
  output logic [7:0]                  rx_fg_rdata_o,
  output logic                        rx_full_flag_o,
  output logic                        rx_irq_o,
  output logic                        overrun_flag_o,
  output logic                        err_irq_o
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    cmb_tx_state_t                          tx_st;
    logic [2:0]                             empty;
    logic [2:0]                             abort_req;
    logic [2:0]                             abort_ack;
    logic [2:0]                             sel;
    logic [1:0]                             cand;
    logic [1:0]                             cur;
    logic [TXB_NUM-1:0][TXB_BYTES-1:0][7:0] txb;
    logic [TXB_NUM-1:0][LOCAL_PRIORITY_FIELD_W-1:0]         local_priority_field;
    logic [TXB_NUM-1:0][STAMP_W-1:0]        tx_stamp;
    logic [TXB_BYTES-1:0][7:0]              tx_frame;
    logic                                   tx_req;
    logic                                   tx_irq;
    logic [7:0]                             tx_rdata;
    logic [RXB_BYTES-1:0][7:0]              bg;
    logic [DEPTH-1:0][RXB_BYTES-1:0][7:0]   fifo;
    logic [PW-1:0]                          wr;
    logic [PW-1:0]                          rd;
    logic [CW-1:0]                          cnt;
    logic                                   rx_full;
    logic                                   rx_irq;
    logic                                   ovr;
    logic                                   err_irq;
    logic                                   ack_allow;
    logic [7:0]                             rx_rdata;
  } cmb_state_t;

  cmb_state_t st_ff;
  cmb_state_t nxt_st;
  logic       sel_valid;
  logic [1:0] sel_idx;

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic [2:0] lowest_bit(input logic [2:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = TXB_NUM - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'h0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic [PW-1:0] next_idx(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  function automatic logic [1:0] onehot_idx(input logic [2:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < TXB_NUM; i++) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------
  // Priority selection
  // ---------------------------------------------------------------------
  cmb_local_priority_field_sel #(
    .NUM (TXB_NUM)
  ) u_local_priority_field_sel (
    .pending_i (~st_ff.empty),
    .local_priority_field_i    (st_ff.local_priority_field),
    .valid_o   (sel_valid),
    .idx_o     (sel_idx)
  );

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    logic [2:0]                set_empty;
    logic [1:0]                widx;
    logic                      win_ok;
    logic                      lock_now;
    logic [1:0]                lock_idx;
    logic                      push_req;
    logic                      pop;
    logic [RXB_BYTES-1:0][7:0] frame;
    set_empty = 3'h0;
    widx      = onehot_idx(st_ff.sel);
    win_ok    = 1'b0;
    lock_now  = 1'b0;
    lock_idx  = 2'h0;
    push_req  = 1'b0;
    pop       = 1'b0;
    frame     = '0;
    nxt_st    = st_ff;

    // Buffer selection maps one empty buffer into the window.
    if (tx_sel_wr_i) begin
      nxt_st.sel = lowest_bit(tx_sel_wdata_i & st_ff.empty);
    end

    // Window writes reach only a selected buffer that is still empty.
    win_ok = (st_ff.sel != 3'h0) && st_ff.empty[widx];
    if (tx_win_wr_i.wr && win_ok) begin
      if (tx_win_wr_i.addr < 4'(TXB_BYTES)) begin
        nxt_st.txb[widx][tx_win_wr_i.addr] = tx_win_wr_i.data;
      end else if (tx_win_wr_i.addr == TXW_LOCAL_PRIORITY_FIELD_OFS) begin
        nxt_st.local_priority_field[widx] = tx_win_wr_i.data;
      end
    end

    // Window read-back, stamp bytes included.
    case (tx_win_raddr_i)
      TXW_LOCAL_PRIORITY_FIELD_OFS:     nxt_st.tx_rdata = st_ff.local_priority_field[widx];
      TXW_STAMP_HI_OFS: nxt_st.tx_rdata = st_ff.tx_stamp[widx][15:8];
      TXW_STAMP_LO_OFS: nxt_st.tx_rdata = st_ff.tx_stamp[widx][7:0];
      default:          nxt_st.tx_rdata = st_ff.txb[widx][tx_win_raddr_i];
    endcase
    if (st_ff.sel == 3'h0) begin
      nxt_st.tx_rdata = BYTE_RST;
    end

    // Transmit scheduling against the protocol engine.
    case (st_ff.tx_st)
      TX_IDLE: begin
        nxt_st.tx_req = sel_valid;
        nxt_st.cand   = sel_idx;
        if (sel_valid) begin
          nxt_st.tx_frame = st_ff.txb[sel_idx];
        end
        if (tx_evt_i.sof && st_ff.tx_req && !st_ff.empty[st_ff.cand]) begin
          lock_now      = 1'b1;
          lock_idx      = st_ff.cand;
          nxt_st.cur    = st_ff.cand;
          nxt_st.tx_st  = TX_BUSY;
          nxt_st.tx_req = 1'b0;
          nxt_st.tx_frame = st_ff.tx_frame;
        end
      end
      TX_BUSY: begin
        lock_now = 1'b1;
        lock_idx = st_ff.cur;
        if (tx_evt_i.done) begin
          set_empty[st_ff.cur] = 1'b1;
          nxt_st.abort_ack[st_ff.cur] = 1'b0;
          if (timestamp_enable_i) begin
            nxt_st.tx_stamp[st_ff.cur] = timer_i;
          end
          nxt_st.tx_st = TX_IDLE;
        end else if (tx_evt_i.lost) begin
          // Lost arbitration or error: selection reruns before retry.
          nxt_st.tx_st = TX_IDLE;
        end
      end
      default: begin
        nxt_st.tx_st  = TX_IDLE;
        nxt_st.tx_req = 1'b0;
      end
    endcase

    // Abort handling; the buffer on the bus is left alone.
    nxt_st.abort_req = st_ff.abort_req | (abort_req_set_i & ~st_ff.empty);
    for (int i = 0; i < TXB_NUM; i++) begin
      if (st_ff.abort_req[i] && !st_ff.empty[i]
          && !(lock_now && lock_idx == 2'(i))) begin
        nxt_st.abort_ack[i] = 1'b1;
        set_empty[i] = 1'b1;
      end
    end

    // Empty flags: hardware set wins over software clear.
    for (int i = 0; i < TXB_NUM; i++) begin
      if (tx_empty_clr_i[i] && st_ff.empty[i] && !set_empty[i]) begin
        nxt_st.abort_ack[i] = 1'b0;
      end
      if (set_empty[i]) begin
        nxt_st.abort_req[i] = 1'b0;
      end
    end
    nxt_st.empty = (st_ff.empty & ~tx_empty_clr_i) | set_empty;
    if (|(st_ff.sel & tx_empty_clr_i & ~set_empty)) begin
      nxt_st.sel = tx_sel_wr_i ? nxt_st.sel : st_ff.sel;
    end
    nxt_st.tx_irq = |(nxt_st.empty & ~tx_irq_mask_i);

    // Background buffer fill while the filter decides.
    if (rx_byte_i.wr && rx_byte_i.addr < 4'(RXB_BYTES)) begin
      nxt_st.bg[rx_byte_i.addr] = rx_byte_i.data;
    end
    frame = nxt_st.bg;
    if (timestamp_enable_i) begin
      frame[RXB_STAMP_HI_OFS] = timer_i[15:8];
      frame[RXB_STAMP_LO_OFS] = timer_i[7:0];
    end

    // Push only valid accepted frames that are not our own, or all in loopback.
    push_req = rx_end_i.eof_ok && rx_end_i.accept
               && (!rx_end_i.own || loopback_i);
    pop = rx_full_clr_i && st_ff.rx_full;
    if (pop) begin
      nxt_st.rd = next_idx(st_ff.rd);
    end
    if (push_req && (st_ff.cnt < CW'(DEPTH) || pop)) begin
      nxt_st.fifo[st_ff.wr] = frame;
      nxt_st.wr = next_idx(st_ff.wr);
    end else if (push_req) begin
      push_req = 1'b0;
      nxt_st.ovr = 1'b1;
    end else if (overrun_clr_i) begin
      nxt_st.ovr = 1'b0;
    end
    if (push_req && !pop) begin
      nxt_st.cnt = CW'(st_ff.cnt + 1'b1);
    end else if (pop && !push_req) begin
      nxt_st.cnt = CW'(st_ff.cnt - 1'b1);
    end
    nxt_st.rx_full  = nxt_st.cnt != '0;
    nxt_st.rx_irq   = nxt_st.rx_full && rx_irq_en_i;
    nxt_st.err_irq  = nxt_st.ovr && overrun_irq_en_i;
    nxt_st.rx_rdata = (rx_fg_raddr_i < 4'(RXB_BYTES))
                      ? nxt_st.fifo[nxt_st.rd][rx_fg_raddr_i] : BYTE_RST;
    if (!nxt_st.rx_full) begin
      nxt_st.rx_rdata = BYTE_RST;
    end

    // Acknowledge only frames of other nodes, or all in loopback.
    nxt_st.ack_allow = (nxt_st.tx_st != TX_BUSY) || loopback_i;
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st_ff           <= '0;
      st_ff.tx_st     <= TX_IDLE;
      st_ff.empty     <= TX_EMPTY_RST;
      st_ff.sel       <= TX_SEL_RST;
      st_ff.local_priority_field      <= {TXB_NUM{LOCAL_PRIORITY_FIELD_RST}};
      st_ff.tx_irq    <= 1'b0;
      st_ff.ack_allow <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign tx_buffer_select_reg_o = st_ff.sel;
  assign tx_buffer_empty_flag_o = st_ff.empty;
  assign abort_request_bit_o    = st_ff.abort_req;
  assign abort_ack_flag_o       = st_ff.abort_ack;
  assign tx_win_rdata_o         = st_ff.tx_rdata;
  assign tx_irq_o               = st_ff.tx_irq;
  assign tx_req_o               = st_ff.tx_req;
  assign tx_frame_o             = st_ff.tx_frame;
  assign tx_busy_o              = st_ff.tx_st[0];
  assign rx_ack_allow_o         = st_ff.ack_allow;
  assign rx_fg_rdata_o          = st_ff.rx_rdata;
  assign rx_full_flag_o         = st_ff.rx_full;
  assign rx_irq_o               = st_ff.rx_irq;
  assign overrun_flag_o         = st_ff.ovr;
  assign err_irq_o              = st_ff.err_irq;

endmodule
`default_nettype wire

// >>> hdl/cmb_pkg.sv
// Shared constants and carrier types of the CAN message buffer store.
package cmb_pkg;

  // ---------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------
  localparam int TXB_NUM   = 3;
  localparam int TXB_BYTES = 13;
  localparam int RXB_BYTES = 15;
  localparam int RX_DEPTH  = 5;
  localparam int LOCAL_PRIORITY_FIELD_W    = 8;
  localparam int STAMP_W   = 16;

  // ---------------------------------------------------------------------
  // Byte offsets inside the transmit window and the receive buffer
  // ---------------------------------------------------------------------
  localparam logic [3:0] TXW_LOCAL_PRIORITY_FIELD_OFS     = 4'hD;
  localparam logic [3:0] TXW_STAMP_HI_OFS = 4'hE;
  localparam logic [3:0] TXW_STAMP_LO_OFS = 4'hF;
  localparam logic [3:0] RXB_STAMP_HI_OFS = 4'hD;
  localparam logic [3:0] RXB_STAMP_LO_OFS = 4'hE;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [2:0] TX_EMPTY_RST = 3'h7;
  localparam logic [2:0] TX_SEL_RST   = 3'h0;
  localparam logic [7:0] LOCAL_PRIORITY_FIELD_RST     = 8'h00;
  localparam logic [7:0] BYTE_RST     = 8'h00;

  // ---------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic [3:0] addr;
    logic [7:0] data;
  } cmb_byte_wr_t;

  typedef struct packed {
    logic eof_ok;
    logic accept;
    logic own;
  } cmb_rx_end_t;

  typedef struct packed {
    logic sof;
    logic done;
    logic lost;
  } cmb_tx_evt_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_BUSY = 2'b01
  } cmb_tx_state_t;

endpackage

// >>> hdl/cmb_local_priority_field_sel.sv
// Local priority selector over the pending transmit buffers.
`timescale 1ns/1ps
`default_nettype none
module cmb_local_priority_field_sel
  import cmb_pkg::*;
#(
  parameter int NUM = TXB_NUM
) (
  input  wire logic [NUM-1:0]             pending_i,
  input  wire logic [NUM-1:0][LOCAL_PRIORITY_FIELD_W-1:0] local_priority_field_i,
  output logic                            valid_o,
  output logic [1:0]                      idx_o
);

  // ---------------------------------------------------------------------
  // Smallest value wins; strict compare keeps the lower index on a tie.
  // ---------------------------------------------------------------------
  always_comb begin
    logic [LOCAL_PRIORITY_FIELD_W-1:0] best;
    best    = {LOCAL_PRIORITY_FIELD_W{1'b1}};
    valid_o = 1'b0;
    idx_o   = 2'h0;
    for (int i = 0; i < NUM; i++) begin
      if (pending_i[i] && (!valid_o || local_priority_field_i[i] < best)) begin
        valid_o = 1'b1;
        best    = local_priority_field_i[i];
        idx_o   = 2'(i);
      end
    end
  end

endmodule
`default_nettype wire

// >>> test/cmb_store_monitor.sv
// Port-level concurrent checks for the message buffer store.
`timescale 1ns/1ps
`default_nettype none
module cmb_store_monitor
  import cmb_pkg::*;
(
  input wire logic                       clk_sys_i,
  input wire logic                       reset_i,
  input wire logic                       loopback_i,
  input wire logic [2:0]                 tx_irq_mask_i,
  input wire cmb_tx_evt_t                tx_evt_i,
  input wire cmb_rx_end_t                rx_end_i,
  input wire logic                       rx_irq_en_i,
  input wire logic [2:0]                 tx_buffer_empty_flag_o,
  input wire logic [2:0]                 abort_ack_flag_o,
  input wire logic                       tx_irq_o,
  input wire logic                       tx_req_o,
  input wire logic [TXB_BYTES-1:0][7:0]  tx_frame_o,
  input wire logic                       tx_busy_o,
  input wire logic                       rx_ack_allow_o,
  input wire logic                       rx_full_flag_o,
  input wire logic                       rx_irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  a_busy_no_req: assert property (tx_busy_o |-> !tx_req_o)
    else $error("request shown while busy");
  a_sof_locks: assert property (
    tx_evt_i.sof && tx_req_o && !tx_busy_o &&
    (tx_buffer_empty_flag_o & ~$past(tx_buffer_empty_flag_o)) == 3'h0
    |=> tx_busy_o)
    else $error("start did not lock a frame");
  a_done_frees: assert property (
    tx_busy_o && tx_evt_i.done |=> !tx_busy_o &&
    $countones(tx_buffer_empty_flag_o) ==
    $countones($past(tx_buffer_empty_flag_o)) + 1)
    else $error("sent frame did not free its buffer");
  a_frame_held: assert property (
    tx_busy_o && !tx_evt_i.done && !tx_evt_i.lost |=> $stable(tx_frame_o))
    else $error("frame changed during transmission");
  a_ack_empty: assert property (
    (abort_ack_flag_o & ~tx_buffer_empty_flag_o) == 3'h0)
    else $error("abort ack on a buffer not released");
  a_tx_irq_set: assert property (
    |(tx_buffer_empty_flag_o & ~tx_irq_mask_i) ##1
    (|(tx_buffer_empty_flag_o & ~tx_irq_mask_i) && $stable(tx_irq_mask_i))
    |-> tx_irq_o)
    else $error("transmit interrupt missing");
  a_reject_drop: assert property (
    rx_end_i.eof_ok && !rx_end_i.accept && !rx_full_flag_o
    |=> !rx_full_flag_o)
    else $error("rejected frame was stored");
  a_own_drop: assert property (
    rx_end_i.eof_ok && rx_end_i.own && !loopback_i && !rx_full_flag_o
    |=> !rx_full_flag_o)
    else $error("own frame was stored");
  a_accept_push: assert property (
    rx_end_i.eof_ok && rx_end_i.accept && (!rx_end_i.own || loopback_i)
    |=> rx_full_flag_o)
    else $error("accepted frame not flagged");
  a_own_no_ack: assert property (
    tx_busy_o && !loopback_i && $stable(loopback_i) |-> !rx_ack_allow_o)
    else $error("own frame acknowledged");
  a_rx_irq_set: assert property (
    $rose(rx_full_flag_o) && rx_irq_en_i |-> rx_irq_o)
    else $error("receive interrupt missing");

  c_sent: cover property (tx_busy_o && tx_evt_i.done);
  c_loop: cover property (rx_end_i.eof_ok && rx_end_i.own && loopback_i);
  c_abort: cover property (|abort_ack_flag_o);
endmodule

bind cmb_store cmb_store_monitor u_mon (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .loopback_i(loopback_i),
  .tx_irq_mask_i(tx_irq_mask_i), .tx_evt_i(tx_evt_i),
  .rx_end_i(rx_end_i), .rx_irq_en_i(rx_irq_en_i),
  .tx_buffer_empty_flag_o(tx_buffer_empty_flag_o),
  .abort_ack_flag_o(abort_ack_flag_o), .tx_irq_o(tx_irq_o),
  .tx_req_o(tx_req_o), .tx_frame_o(tx_frame_o), .tx_busy_o(tx_busy_o),
  .rx_ack_allow_o(rx_ack_allow_o), .rx_full_flag_o(rx_full_flag_o),
  .rx_irq_o(rx_irq_o)
);
`default_nettype wire

// >>> test/cmb_can_partner.sv
// Behavioural protocol engine and bus traffic feeding the store.
`timescale 1ns/1ps
`default_nettype none
module cmb_can_partner
  import cmb_pkg::*;
(
  input  wire logic          clk_sys_i,
  output var cmb_tx_evt_t    tx_evt_o,
  output var cmb_byte_wr_t   rx_byte_o,
  output var cmb_rx_end_t    rx_end_o
);
  initial begin
    tx_evt_o = '0;
    rx_byte_o = '0;
    rx_end_o = '0;
  end

  task automatic tx_pulse(input logic [2:0] ev);
    tx_evt_o = ev;
    @(negedge clk_sys_i);
    tx_evt_o = '0;
  endtask

  // Gap above zero models a slow sender; released data is inverted.
  task automatic frame(input logic [7:0] base, input logic acc, own,
                       input int gap);
    for (int i = 0; i < RXB_BYTES; i++) begin
      rx_byte_o = {1'b1, 4'(i), base + 8'(i)};
      @(negedge clk_sys_i);
      if (gap > 0) begin
        rx_byte_o.wr = 1'b0;
        rx_byte_o.data = ~rx_byte_o.data;
        repeat (gap) @(negedge clk_sys_i);
      end
    end
    rx_byte_o.wr = 1'b0;
    rx_end_o = {1'b1, acc, own};
    @(negedge clk_sys_i);
    rx_end_o = {1'b0, ~acc, ~own};
  endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the message buffer store.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cmb_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic loopback = 1'b0, ts_en = 1'b0, sel_wr = 1'b0, rx_clr = 1'b0;
  logic [15:0] timer = 16'hBEEF;
  logic [2:0] sel = 3'h0, e_clr = 3'h0, ab_set = 3'h0, mask = 3'h0;
  logic [3:0] rx_ra = 4'h0, win_ra = 4'h0;
  logic [7:0] win_rd;
  logic ack_ok;
  cmb_byte_wr_t win = '0;
  cmb_byte_wr_t rx_byte;
  cmb_tx_evt_t evt;
  cmb_rx_end_t rx_end;
  logic [2:0] sel_q, empty, ab_q, ack;
  logic [7:0] rx_rd;
  logic tx_irq, tx_req, busy, full, rx_irq, ovr, err_irq;
  logic [TXB_BYTES-1:0][7:0] frame;
  int err_total = 0, check_count = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  cmb_can_partner u_bus (.clk_sys_i(clk_sys_i), .tx_evt_o(evt),
    .rx_byte_o(rx_byte), .rx_end_o(rx_end));

  cmb_store uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .loopback_i(loopback), .timestamp_enable_i(ts_en), .timer_i(timer),
    .tx_sel_wr_i(sel_wr), .tx_sel_wdata_i(sel), .tx_win_wr_i(win),
    .tx_win_raddr_i(win_ra), .tx_empty_clr_i(e_clr),
    .abort_req_set_i(ab_set), .tx_irq_mask_i(mask), .tx_evt_i(evt),
    .rx_byte_i(rx_byte), .rx_end_i(rx_end), .rx_fg_raddr_i(rx_ra),
    .rx_full_clr_i(rx_clr), .rx_irq_en_i(1'b1), .overrun_clr_i(1'b0),
    .overrun_irq_en_i(1'b1), .tx_buffer_select_reg_o(sel_q),
    .tx_buffer_empty_flag_o(empty), .abort_request_bit_o(ab_q),
    .abort_ack_flag_o(ack), .tx_win_rdata_o(win_rd), .tx_irq_o(tx_irq),
    .tx_req_o(tx_req), .tx_frame_o(frame), .tx_busy_o(busy),
    .rx_ack_allow_o(ack_ok), .rx_fg_rdata_o(rx_rd), .rx_full_flag_o(full),
    .rx_irq_o(rx_irq), .overrun_flag_o(ovr), .err_irq_o(err_irq));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // Select a buffer, fill frame bytes and priority, then mark it ready.
  task automatic load(input int b, input logic [7:0] local_priority_field, base);
    sel = 3'h1 << b;
    sel_wr = 1'b1;
    tick();
    sel_wr = 1'b0;
    chk(sel_q, sel);
    for (int a = 0; a < 14; a++) begin
      win = {1'b1, 4'(a), (a == 13) ? local_priority_field : base + 8'(a)};
      tick();
    end
    win.wr = 1'b0;
    win_ra = TXW_LOCAL_PRIORITY_FIELD_OFS;
    tick();
    chk(win_rd, local_priority_field);
    e_clr = sel;
    tick();
    e_clr = 3'h0;
  endtask

  task automatic start(input logic [7:0] exp);
    for (int i = 0; i < 100 && tx_req !== 1'b1; i++) tick();
    if (tx_req !== 1'b1) begin
      chk(tx_req, 1'b1);
      final_report();
    end
    chk(frame[0], exp);
    u_bus.tx_pulse(3'b100);
    tick(2);
  endtask

  task automatic send(input logic [7:0] exp, input logic lose);
    start(exp);
    u_bus.tx_pulse(lose ? 3'b001 : 3'b010);
  endtask

  task automatic s_local_priority_field;
    load(0, 8'h05, 8'h10);
    load(1, 8'h03, 8'h20);
    load(2, 8'h03, 8'h30);
    chk(tx_irq, 1'b0);
    send(8'h20, 1'b0);
    chk(empty, 3'b010);
    chk(ack, 3'b000);
    chk(tx_irq, 1'b1);
    mask = 3'h2;
    tick();
    chk(tx_irq, 1'b0);
    mask = 3'h0;
    send(8'h30, 1'b1);
    send(8'h30, 1'b0);
    chk(empty, 3'b110);
    send(8'h10, 1'b0);
    chk(empty, 3'b111);
  endtask

  task automatic s_abort;
    load(0, 8'h01, 8'h40);
    load(1, 8'h02, 8'h50);
    start(8'h40);
    chk(ack_ok, 1'b0);
    ab_set = 3'b011;
    tick();
    ab_set = 3'b000;
    tick(2);
    chk(ack, 3'b010);
    chk(empty, 3'b110);
    chk(tx_irq, 1'b1);
    u_bus.tx_pulse(3'b010);
    chk(ack, 3'b010);
    chk(empty, 3'b111);
    chk(ack_ok, 1'b1);
  endtask

  task automatic pop(input logic [7:0] exp);
    rx_ra = 4'h0;
    tick();
    chk(rx_rd, exp);
    rx_clr = 1'b1;
    tick();
    rx_clr = 1'b0;
  endtask

  task automatic s_rx;
    u_bus.frame(8'h70, 1'b0, 1'b0, 0);
    u_bus.frame(8'h71, 1'b1, 1'b1, 0);
    chk(full, 1'b0);
    ts_en = 1'b1;
    u_bus.frame(8'h60, 1'b1, 1'b0, 1);
    ts_en = 1'b0;
    chk({full, rx_irq}, 2'b11);
    rx_ra = RXB_STAMP_HI_OFS;
    tick();
    chk(rx_rd, timer[15:8]);
    loopback = 1'b1;
    u_bus.frame(8'h61, 1'b1, 1'b1, 0);
    loopback = 1'b0;
    for (int i = 2; i < 6; i++) u_bus.frame(8'h60 + 8'(i), 1'b1, 1'b0, 0);
    chk({ovr, err_irq}, 2'b11);
    pop(8'h60);
    u_bus.frame(8'h66, 1'b1, 1'b0, 0);
    for (int i = 1; i < 5; i++) pop(8'h60 + 8'(i));
    pop(8'h66);
    chk(full, 1'b0);
  endtask

  initial begin
    tick(12);
    reset_i = 1'b0;
    tick();
    chk({empty, sel_q, full}, {TX_EMPTY_RST, TX_SEL_RST, 1'b0});
    s_local_priority_field();
    s_abort();
    s_rx();
    final_report();
  end
endmodule
`default_nettype wire
